// ---- oaid_pkg.sv ----
/*
 * Shared constants and types for the OR / extended-instruction decode block.
 * Assumes one 250 MHz core clock; data memory answers a registered read address
 * within the same clock cycle in which that address is presented.
 */
// What this block does
// - OR 8-bit literal into accumulator, update N and Z, one word, one cycle.
// - OR accumulator with file register; d=0 writes accumulator, d=1 writes file.
// - Extended set on and a=0: file address 95 or less is pointer-2 indexed.
// - Configuration bit enables extended set; unprogrammed state means enabled.
// - E8 opcode adds 6-bit literal to pointer ff; ff=11 adds pointer 2, returns.
// - E9 opcode subtracts 6-bit literal from pointer ff; ff=11 also returns.
// - Return variants return after pointer 2 arithmetic, leaving flags untouched.
// - Fixed opcode 0014 calls subroutine targeted by accumulator, two cycles, no flags.
// - EB move, bit7 clear: 7-bit source offset, second word 12-bit absolute target.
// - EB move, bit7 set: 7-bit source offset, second word 7-bit indexed target.
// - EA opcode stores literal at pointer 2, then decrements it, no flags.
package oaid_pkg;

    // ****************************************************************
    // Opcode fields
    // ****************************************************************
    localparam logic [7:0] OAID_OR_LIT_HI = 8'h09;
    localparam logic [5:0] OAID_OR_FILE_HI = 6'h04;
    localparam logic [15:0] OAID_CALL_ACC = 16'h0014;
    localparam logic [7:0] OAID_PTR_ADD_HI = 8'hE8;
    localparam logic [7:0] OAID_PTR_SUB_HI = 8'hE9;
    localparam logic [7:0] OAID_PUSH_HI = 8'hEA;
    localparam logic [7:0] OAID_MOVE_HI = 8'hEB;
    localparam logic [3:0] OAID_WORD2_HI = 4'hF;
    localparam logic [1:0] OAID_FSEL_STACK = 2'h3;

    // ****************************************************************
    // Addressing
    // ****************************************************************
    localparam logic [7:0] OAID_INDEX_LIMIT = 8'h5F;
    localparam logic [3:0] OAID_SFR_BANK = 4'hF;
    localparam int OAID_ADDR_W = 12;
    localparam int OAID_STRAP_SETTLE = 3;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic OAID_EXT_RESET = 1'b1;
    localparam logic [7:0] OAID_ACC_RESET = 8'h00;
    localparam logic [11:0] OAID_PTR_RESET = 12'h000;

    typedef enum logic [3:0] {
        OAID_OP_NONE, OAID_OP_OR_LIT, OAID_OP_OR_FILE, OAID_OP_PADD, OAID_OP_PSUB,
        OAID_OP_CALL, OAID_OP_MOVE1, OAID_OP_PUSH, OAID_OP_WORD2
    } oaid_op_t;

    typedef enum logic [2:0] {
        OAID_ST_START, OAID_ST_IDLE, OAID_ST_OR_READ, OAID_ST_RET, OAID_ST_CALL,
        OAID_ST_MV_WORD2, OAID_ST_MV_READ
    } oaid_state_t;

endpackage

// ---- oaid_decoder.sv ----
/*
 * Decode and execute unit for the inclusive-OR instructions and the
 * extended pointer, call, move and push instructions of an 8-bit core.
 * Assumes an instruction source that offers one word at a time with a
 * valid strobe, and a data memory whose read data is valid in the cycle
 * in which mem_rd_out is high.
 */
`timescale 1ns/1ps

module oaid_decoder
    import oaid_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Configuration strap, from outside the clock domain
    input wire logic ext_cfg_pin_in,
    // Instruction words
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_word_in,
    input wire logic [3:0] bank_select_in,
    output logic instr_ready_out,
    output logic not_decoded_out,
    // Data memory port
    output logic [11:0] mem_addr_out,
    output logic mem_rd_out,
    output logic mem_wr_out,
    output logic [7:0] mem_wdata_out,
    input wire logic [7:0] mem_rdata_in,
    // Program flow requests
    output logic call_out,
    output logic [7:0] call_target_out,
    output logic return_out,
    // Architectural state
    output logic [7:0] accumulator_reg_out,
    output logic negative_out,
    output logic zero_out,
    output logic [11:0] pointer0_out,
    output logic [11:0] pointer1_out,
    output logic [11:0] stack_pointer_reg_out,
    output logic extended_set_enable_bit_out
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Classify one instruction word
    function automatic oaid_op_t decode_op(input logic [15:0] w, input logic ext);
        oaid_op_t op;
        op = OAID_OP_NONE;
        if (w[15:8] == OAID_OR_LIT_HI) begin
            op = OAID_OP_OR_LIT;
        end else if (w[15:10] == OAID_OR_FILE_HI) begin
            op = OAID_OP_OR_FILE;
        end else if (ext && w == OAID_CALL_ACC) begin
            op = OAID_OP_CALL;
        end else if (ext && w[15:8] == OAID_PTR_ADD_HI) begin
            op = OAID_OP_PADD;
        end else if (ext && w[15:8] == OAID_PTR_SUB_HI) begin
            op = OAID_OP_PSUB;
        end else if (ext && w[15:8] == OAID_PUSH_HI) begin
            op = OAID_OP_PUSH;
        end else if (ext && w[15:8] == OAID_MOVE_HI) begin
            op = OAID_OP_MOVE1;
        end else if (w[15:12] == OAID_WORD2_HI) begin
            op = OAID_OP_WORD2;
        end
        return op;
    endfunction

    // Pointer 2 plus an unsigned offset, wrapped to the address width
    function automatic logic [11:0] index_addr(input logic [11:0] base, input logic [7:0] off);
        return base + {4'h0, off};
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    oaid_state_t state_reg;
    logic cfg_sync1_reg;
    logic cfg_sync2_reg;
    logic [1:0] cfg_wait_reg;
    logic ext_reg;
    logic [7:0] acc_reg;
    logic neg_reg;
    logic zero_reg;
    logic [11:0] ptr_reg [3];
    logic or_to_file_reg;
    logic [11:0] mv_src_reg;
    logic mv_indexed_reg;
    logic [11:0] mv_dst_reg;

    logic take_first;
    logic take_second;
    oaid_op_t op;
    logic [11:0] file_addr;
    logic [7:0] or_result;
    logic [11:0] ptr_lit;

    // ****************************************************************
    // Decode
    // ****************************************************************

    // Words are only taken while ready; the move's second word has its own slot
    always_comb begin
        take_first = instr_valid_in && state_reg == OAID_ST_IDLE;
        take_second = instr_valid_in && state_reg == OAID_ST_MV_WORD2;
        op = decode_op(instr_word_in, ext_reg);
        ptr_lit = {6'h00, instr_word_in[5:0]};
        or_result = acc_reg | mem_rdata_in;
        if (state_reg != OAID_ST_OR_READ) begin
            or_result = acc_reg | instr_word_in[7:0];
        end
    end

    // File address: banked, access bank, or pointer-2 indexed when small
    always_comb begin
        if (instr_word_in[8]) begin
            file_addr = {bank_select_in, instr_word_in[7:0]};
        end else if (ext_reg && instr_word_in[7:0] <= OAID_INDEX_LIMIT) begin
            file_addr = index_addr(ptr_reg[2], instr_word_in[7:0]);
        end else if (instr_word_in[7:0] <= OAID_INDEX_LIMIT) begin
            file_addr = {4'h0, instr_word_in[7:0]};
        end else begin
            file_addr = {OAID_SFR_BANK, instr_word_in[7:0]};
        end
    end

    // ****************************************************************
    // Configuration strap
    // ****************************************************************

    // Strap crosses two flops; read only after the synchroniser has settled
    always_ff @(posedge ref_clk_in) begin
        cfg_sync1_reg <= ext_cfg_pin_in;
        cfg_sync2_reg <= cfg_sync1_reg;
    end

    // Unprogrammed part reads as enabled until the strap is captured
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ext_reg <= OAID_EXT_RESET;
            cfg_wait_reg <= 2'h0;
        end else if (state_reg == OAID_ST_START) begin
            cfg_wait_reg <= cfg_wait_reg + 2'h1;
            if (cfg_wait_reg == 2'(OAID_STRAP_SETTLE - 1)) begin
                ext_reg <= cfg_sync2_reg;
            end
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************

    // Two-cycle instructions hold ready low for one extra cycle
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_reg <= OAID_ST_START;
            instr_ready_out <= 1'b0;
        end else begin
            case (state_reg)
                OAID_ST_START: begin
                    if (cfg_wait_reg == 2'(OAID_STRAP_SETTLE - 1)) begin
                        state_reg <= OAID_ST_IDLE;
                        instr_ready_out <= 1'b1;
                    end
                end
                OAID_ST_IDLE: begin
                    if (take_first) begin
                        case (op)
                            OAID_OP_OR_FILE: begin
                                state_reg <= OAID_ST_OR_READ;
                                instr_ready_out <= 1'b0;
                            end
                            OAID_OP_PADD, OAID_OP_PSUB: begin
                                if (instr_word_in[7:6] == OAID_FSEL_STACK) begin
                                    state_reg <= OAID_ST_RET;
                                    instr_ready_out <= 1'b0;
                                end
                            end
                            OAID_OP_CALL: begin
                                state_reg <= OAID_ST_CALL;
                                instr_ready_out <= 1'b0;
                            end
                            OAID_OP_MOVE1: begin
                                state_reg <= OAID_ST_MV_WORD2;
                            end
                            default: begin
                                state_reg <= OAID_ST_IDLE;
                            end
                        endcase
                    end
                end
                OAID_ST_MV_WORD2: begin
                    if (take_second && instr_word_in[15:12] == OAID_WORD2_HI) begin
                        state_reg <= OAID_ST_MV_READ;
                        instr_ready_out <= 1'b0;
                    end else if (take_second) begin
                        state_reg <= OAID_ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= OAID_ST_IDLE;
                    instr_ready_out <= 1'b1;
                end
            endcase
        end
    end

    // Flag words that this slice does not execute, or a broken move pair
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            not_decoded_out <= 1'b0;
        end else begin
            not_decoded_out <= (take_first && op == OAID_OP_NONE) ||
                (take_second && instr_word_in[15:12] != OAID_WORD2_HI);
        end
    end

    // ****************************************************************
    // Accumulator and flags
    // ****************************************************************

    // Only the OR instructions touch N and Z; all extended ones leave them
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            acc_reg <= OAID_ACC_RESET;
            neg_reg <= 1'b0;
            zero_reg <= 1'b0;
            or_to_file_reg <= 1'b0;
        end else if (take_first && op == OAID_OP_OR_LIT) begin
            acc_reg <= or_result;
            neg_reg <= or_result[7];
            zero_reg <= or_result == 8'h00;
        end else if (take_first && op == OAID_OP_OR_FILE) begin
            or_to_file_reg <= instr_word_in[9];
        end else if (state_reg == OAID_ST_OR_READ) begin
            if (!or_to_file_reg) begin
                acc_reg <= or_result;
            end
            neg_reg <= or_result[7];
            zero_reg <= or_result == 8'h00;
        end
    end

    // ****************************************************************
    // Pointer registers
    // ****************************************************************

    // Return variants always hit pointer 2, which is what ff=11 selects anyway
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < 3; i++) begin
                ptr_reg[i] <= OAID_PTR_RESET;
            end
        end else if (take_first && op == OAID_OP_PADD) begin
            if (instr_word_in[7:6] == OAID_FSEL_STACK) begin
                ptr_reg[2] <= ptr_reg[2] + ptr_lit;
            end else begin
                ptr_reg[instr_word_in[7:6]] <= ptr_reg[instr_word_in[7:6]] + ptr_lit;
            end
        end else if (take_first && op == OAID_OP_PSUB) begin
            if (instr_word_in[7:6] == OAID_FSEL_STACK) begin
                ptr_reg[2] <= ptr_reg[2] - ptr_lit;
            end else begin
                ptr_reg[instr_word_in[7:6]] <= ptr_reg[instr_word_in[7:6]] - ptr_lit;
            end
        end else if (take_first && op == OAID_OP_PUSH) begin
            ptr_reg[2] <= ptr_reg[2] - 12'h001;
        end
    end

    // ****************************************************************
    // Move operands
    // ****************************************************************

    // Source is fixed at the first word, so a later pointer change cannot skew it
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            mv_src_reg <= OAID_PTR_RESET;
            mv_indexed_reg <= 1'b0;
            mv_dst_reg <= OAID_PTR_RESET;
        end else if (take_first && op == OAID_OP_MOVE1) begin
            mv_src_reg <= index_addr(ptr_reg[2], {1'b0, instr_word_in[6:0]});
            mv_indexed_reg <= instr_word_in[7];
        end else if (take_second) begin
            if (mv_indexed_reg) begin
                mv_dst_reg <= index_addr(ptr_reg[2], {1'b0, instr_word_in[6:0]});
            end else begin
                mv_dst_reg <= instr_word_in[11:0];
            end
        end
    end

    // ****************************************************************
    // Data memory port
    // ****************************************************************

    // Strobes are one-cycle pulses; address and data hold until the next access
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            mem_addr_out <= OAID_PTR_RESET;
            mem_rd_out <= 1'b0;
            mem_wr_out <= 1'b0;
            mem_wdata_out <= 8'h00;
        end else begin
            mem_rd_out <= 1'b0;
            mem_wr_out <= 1'b0;
            if (take_first && op == OAID_OP_OR_FILE) begin
                mem_addr_out <= file_addr;
                mem_rd_out <= 1'b1;
            end else if (take_first && op == OAID_OP_PUSH) begin
                mem_addr_out <= ptr_reg[2];
                mem_wdata_out <= instr_word_in[7:0];
                mem_wr_out <= 1'b1;
            end else if (state_reg == OAID_ST_OR_READ && or_to_file_reg) begin
                mem_wdata_out <= or_result;
                mem_wr_out <= 1'b1;
            end else if (take_second && instr_word_in[15:12] == OAID_WORD2_HI) begin
                mem_addr_out <= mv_src_reg;
                mem_rd_out <= 1'b1;
            end else if (state_reg == OAID_ST_MV_READ) begin
                mem_addr_out <= mv_dst_reg;
                mem_wdata_out <= mem_rdata_in;
                mem_wr_out <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Program flow
    // ****************************************************************

    // Call and return pulse in the cycle after the second cycle of their instruction
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            call_out <= 1'b0;
            return_out <= 1'b0;
            call_target_out <= 8'h00;
        end else begin
            call_out <= state_reg == OAID_ST_CALL;
            return_out <= state_reg == OAID_ST_RET;
            if (take_first && op == OAID_OP_CALL) begin
                call_target_out <= acc_reg;
            end
        end
    end

    // ****************************************************************
    // State outputs
    // ****************************************************************
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            accumulator_reg_out <= OAID_ACC_RESET;
            negative_out <= 1'b0;
            zero_out <= 1'b0;
            pointer0_out <= OAID_PTR_RESET;
            pointer1_out <= OAID_PTR_RESET;
            stack_pointer_reg_out <= OAID_PTR_RESET;
            extended_set_enable_bit_out <= OAID_EXT_RESET;
        end else begin
            accumulator_reg_out <= acc_reg;
            negative_out <= neg_reg;
            zero_out <= zero_reg;
            pointer0_out <= ptr_reg[0];
            pointer1_out <= ptr_reg[1];
            stack_pointer_reg_out <= ptr_reg[2];
            extended_set_enable_bit_out <= ext_reg;
        end
    end

endmodule

// ---- oaid_monitor.sv ----
/*
 * Concurrent checks for the OR / extended decode block.
 * Assumes it is bound to oaid_decoder and sees only that module's ports.
 */
`timescale 1ns/1ps

module oaid_monitor
    import oaid_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Instruction side
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_word_in,
    input wire logic [3:0] bank_select_in,
    input wire logic instr_ready_out,
    input wire logic not_decoded_out,
    // Memory and flow
    input wire logic [11:0] mem_addr_out,
    input wire logic mem_rd_out,
    input wire logic mem_wr_out,
    input wire logic [7:0] mem_wdata_out,
    input wire logic call_out,
    input wire logic return_out,
    // State copies
    input wire logic [7:0] accumulator_reg_out,
    input wire logic negative_out,
    input wire logic zero_out,
    input wire logic [11:0] stack_pointer_reg_out,
    input wire logic extended_set_enable_bit_out
);
    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    // Shared terms keep each property short
    logic take, ext, or_file, ptr_ret;
    assign take = instr_valid_in && instr_ready_out;
    assign ext = extended_set_enable_bit_out;
    assign or_file = take && (instr_word_in[15:10] == OAID_OR_FILE_HI);
    assign ptr_ret = take && ext && (instr_word_in[7:6] == OAID_FSEL_STACK)
        && (instr_word_in[15:9] == OAID_PTR_ADD_HI[7:1]);

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_or_flags: assert property ($changed(accumulator_reg_out) |->
        zero_out == (accumulator_reg_out == 8'h00) && negative_out == accumulator_reg_out[7])
        else $error("flags disagree with accumulator");
    a_ext_refused: assert property (take && !ext && instr_word_in[15:10] == 6'h3A
        |=> not_decoded_out) else $error("extended opcode ran with set off");
    a_push_write: assert property (take && ext && instr_word_in[15:8] == OAID_PUSH_HI
        |=> mem_wr_out && mem_wdata_out == $past(instr_word_in[7:0]))
        else $error("push literal not written");
    a_call_seq: assert property (take && ext && instr_word_in == OAID_CALL_ACC
        |=> !instr_ready_out ##1 (call_out && instr_ready_out)) else $error("call timing");
    a_return_seq: assert property (ptr_ret |=> !instr_ready_out && !return_out
        ##1 return_out) else $error("return variant timing");
    a_file_write: assert property (or_file && instr_word_in[9] |=> mem_rd_out
        ##1 (mem_wr_out && mem_addr_out == $past(mem_addr_out))) else $error("or file write");
    a_file_keep: assert property (or_file && !instr_word_in[9] |=> mem_rd_out
        ##1 !mem_wr_out) else $error("or file wrote memory with d clear");
    a_index_addr: assert property (or_file && ext && !instr_word_in[8]
        && instr_word_in[7:0] <= OAID_INDEX_LIMIT |=> mem_addr_out ==
        stack_pointer_reg_out + {4'h0, $past(instr_word_in[7:0])}) else $error("index address");
    a_bank_addr: assert property (or_file && instr_word_in[8] |=> mem_addr_out ==
        {$past(bank_select_in), $past(instr_word_in[7:0])}) else $error("banked address");
    a_move_pair: assert property (take && ext && instr_word_in[15:8] == OAID_MOVE_HI
        ##1 take && instr_word_in[15:12] == OAID_WORD2_HI |=> mem_rd_out ##1 mem_wr_out)
        else $error("move read then write");

    // Main scenarios reached
    c_call: cover property (call_out);
    c_return: cover property (return_out);
    c_move: cover property (mem_rd_out ##1 mem_wr_out);
endmodule

bind oaid_decoder oaid_monitor mon_u (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in),
    .bank_select_in(bank_select_in), .instr_ready_out(instr_ready_out),
    .not_decoded_out(not_decoded_out), .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out), .call_out(call_out),
    .return_out(return_out), .accumulator_reg_out(accumulator_reg_out),
    .negative_out(negative_out), .zero_out(zero_out),
    .stack_pointer_reg_out(stack_pointer_reg_out),
    .extended_set_enable_bit_out(extended_set_enable_bit_out));

// ---- oaid_tb.sv ----
/*
 * Self-checking bench for the OR / extended decode block.
 * Assumes the bench alone drives every input and plays the data memory.
 */
`timescale 1ns/1ps

module testbench;
    import oaid_pkg::*;
    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic strap = 1'b1;
    logic valid = 1'b0;
    logic [15:0] word = 16'h0000;
    logic [3:0] bank = 4'h0;
    logic [7:0] rdata = 8'h00;
    logic ready, nd, rd, wr, call, ret, neg, zero, ext;
    logic [11:0] addr, p0, p1, p2;
    logic [7:0] wdata, tgt, acc;
    int bad_count = 0;
    int check_count = 0;

    // Free-running 250 MHz clock
    always #2 clk = ~clk;

    oaid_decoder dut_u (.ref_clk_in(clk), .sys_rst_in(rst), .ext_cfg_pin_in(strap),
        .instr_valid_in(valid), .instr_word_in(word), .bank_select_in(bank),
        .instr_ready_out(ready), .not_decoded_out(nd), .mem_addr_out(addr),
        .mem_rd_out(rd), .mem_wr_out(wr), .mem_wdata_out(wdata), .mem_rdata_in(rdata),
        .call_out(call), .call_target_out(tgt), .return_out(ret),
        .accumulator_reg_out(acc), .negative_out(neg), .zero_out(zero),
        .pointer0_out(p0), .pointer1_out(p1), .stack_pointer_reg_out(p2),
        .extended_set_enable_bit_out(ext));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic end_sim();
        if (bad_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check_word(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Offer a word at this edge; returns at the taking edge. Hold keeps valid up
    task automatic issue(input logic [15:0] w, input logic hold);
        int i;
        valid <= 1'b1;
        word <= w;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (ready === 1'b1) break;
        end
        if (i == 20) begin
            bad_count++;
            end_sim();
        end
        if (!hold) valid <= 1'b0;
    endtask

    // Step one cycle and look once outputs have settled
    task automatic nxt();
        @(posedge clk);
        #1;
    endtask

    // Strap is set well ahead of release so the capture sees it stable
    task automatic do_reset(input logic s);
        int i;
        strap <= s;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check_bit(ext, 1'b1);
        @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 20 && ready !== 1'b1; i++) @(posedge clk);
        if (i == 20) begin
            bad_count++;
            end_sim();
        end
        #1;
        check_bit(ext, s);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Zero result first, then two literals back to back
    task automatic t_or_lit();
        issue(16'h0900, 1'b0);
        nxt();
        check_bit(zero, 1'b1);
        @(posedge clk);
        issue(16'h099A, 1'b1);
        issue(16'h0935, 1'b0);
        nxt();
        check_word({4'h0, acc}, 12'h0BF);
        check_bit(neg, 1'b1);
        check_bit(zero, 1'b0);
        @(posedge clk);
    endtask

    // Return variants must stall one cycle and leave the flags alone
    task automatic ret_case(input logic [15:0] w, input logic [11:0] exp);
        issue(w, 1'b0);
        #1;
        check_bit(ready, 1'b0);
        nxt();
        check_word(p2, exp);
        check_bit(ret, 1'b1);
        check_bit(neg, 1'b1);
        @(posedge clk);
    endtask

    // Pointer arithmetic, including wrap below zero
    task automatic t_pointer();
        issue(16'hE83F, 1'b0);
        nxt();
        check_word(p0, 12'h03F);
        @(posedge clk);
        issue(16'hE945, 1'b0);
        nxt();
        check_word(p1, 12'hFFB);
        @(posedge clk);
        ret_case(16'hE8E0, 12'h020);
        ret_case(16'hE9C1, 12'h01F);
    endtask

    // Call target, push, then OR with memory using the moved pointer
    task automatic t_call_push_file();
        issue(OAID_CALL_ACC, 1'b0);
        #1;
        check_word({4'h0, tgt}, 12'h0BF);
        nxt();
        check_bit(call, 1'b1);
        @(posedge clk);
        issue(16'hEA5A, 1'b0);
        #1;
        check_word({wr, 3'h0, wdata}, 12'h85A);
        check_word(addr, 12'h01F);
        nxt();
        check_word(p2, 12'h01E);
        @(posedge clk);
        rdata <= 8'h40;
        issue(16'h1210, 1'b0);
        #1;
        check_word(addr, 12'h02E);
        nxt();
        check_word({wr, 3'h0, wdata}, 12'h8FF);
        @(posedge clk);
        issue(16'h1060, 1'b0);
        #1;
        check_word(addr, 12'hF60);
        nxt();
        check_bit(wr, 1'b0);
        nxt();
        check_word({4'h0, acc}, 12'h0FF);
        @(posedge clk);
        bank <= 4'h3;
        issue(16'h1147, 1'b0);
        #1;
        check_word(addr, 12'h347);
        @(posedge clk);
    endtask

    // Both move forms, second word straight after the first
    task automatic move_case(input logic [15:0] w1, input logic [15:0] w2,
        input logic [7:0] d, input logic [11:0] dst);
        rdata <= d;
        issue(w1, 1'b1);
        issue(w2, 1'b0);
        #1;
        check_word({rd, 3'h0, addr[7:0]}, 12'h823);
        nxt();
        check_word(addr, dst);
        check_word({wr, 3'h0, wdata}, {4'h8, d});
        @(posedge clk);
    endtask

    // Extended set strapped off: extended words refused
    task automatic t_ext_off();
        do_reset(1'b0);
        issue(16'hE801, 1'b0);
        #1;
        check_bit(nd, 1'b1);
        nxt();
        check_word(p0, 12'h000);
    endtask

    initial begin
        do_reset(1'b1);
        t_or_lit();
        t_pointer();
        t_call_push_file();
        move_case(16'hEB05, 16'hF123, 8'h77, 12'h123);
        move_case(16'hEB85, 16'hF003, 8'h66, 12'h021);
        t_ext_off();
        end_sim();
    end
endmodule
